// ### rtl/itwle_exec.sv
`timescale 1ns/1ps
`include "itwle_cfg.svh"
module itwle_exec
#(
  parameter bit RELEASE2 = 1'b1, // Release 2 instruction set present
  parameter bit WAKE_ON_MASKED = 1'b0, // Masked request also wakes
  parameter int SETS_W = 4 // Width of shadow set number
)
(
  input wire logic clock, // Core clock, 125 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic issue_valid, // Instruction presented this cycle
  input wire logic [31:0] issue_instr, // Instruction word
  input wire logic [31:0] issue_pc, // Address of the instruction
  input wire logic [31:0] opnd_a, // Value of source_reg_a
  input wire logic [31:0] opnd_b, // Value of source_reg_b
  input wire logic syscop_usable, // System coprocessor access allowed
  input wire logic [SETS_W-1:0] previous_shadow_set, // From shadow ctl
  input wire logic irq_pending, // Interrupt request pin, raw
  input wire logic irq_enabled, // Request is enabled, raw
  input wire logic nmi_in, // Non-maskable interrupt pin, raw
  output logic issue_ready, // Pipeline may present next, registered
  output logic claimed_r, // Instruction was one of ours
  output logic wr_en_r, // Write current-set register
  output logic [4:0] wr_idx_r, // Destination register number
  output logic [31:0] wr_data_r, // Write data
  output logic sh_wr_en_r, // Write shadow-set register
  output logic [SETS_W-1:0] sh_set_r, // Shadow set number
  output logic exc_valid_r, // Exception request pulse
  output itwle_pkg::itwle_exc_type exc_code_r, // Exception kind
  output logic [31:0] exc_pc_r, // Exception return address
  output logic standby_r, // Pipeline stalled in standby
  output logic wake_masked_r // Woke on non-enabled request, poll
);
  // Standby control states
  typedef enum logic [1:0] {
    ITWLE_RUN,
    ITWLE_SLEEP
  } itwle_state_type;

  itwle_state_type state_r; // Standby state
  itwle_pkg::itwle_op_type op; // Decoded operation
  logic [31:0] resume_pc_r; // Successor of the standby instruction
  logic [2:0] irq_s1_r; // Pin synchroniser, first stage
  logic [2:0] irq_s2_r; // Pin synchroniser, second stage
  logic irq_p; // Synchronised pending
  logic irq_e; // Synchronised enable
  logic nmi_s; // Synchronised NMI
  logic fire; // Accepted instruction this cycle
  logic [31:0] imm_sx; // Sign-extended immediate
  logic [31:0] imm_zx; // Zero-extended immediate
  logic [4:0] srcb_f; // Second source register field
  logic [4:0] rd_f; // rd field
  logic reserved_op; // Release 2 only op on older part
  logic trap_hit; // Trap condition met
  logic wake_ev; // Any event that ends standby

  itwle_decode u_dec
  (
    .instr(issue_instr),
    .op(op)
  );

  // Halfword byte swap of a word
  function automatic logic [31:0] swap_halves(input logic [31:0] v);
    swap_halves = {v[23:16], v[31:24], v[7:0], v[15:8]};
  endfunction

  assign imm_sx = {{16{issue_instr[`ITWLE_IMM_HI]}},
                   issue_instr[`ITWLE_IMM_HI:`ITWLE_IMM_LO]};
  assign imm_zx = {16'h0000, issue_instr[`ITWLE_IMM_HI:`ITWLE_IMM_LO]};
  assign srcb_f = issue_instr[`ITWLE_SRCB_HI:`ITWLE_SRCB_LO];
  assign rd_f = issue_instr[`ITWLE_RD_HI:`ITWLE_RD_LO];
  assign irq_p = irq_s2_r[0];
  assign irq_e = irq_s2_r[1];
  assign nmi_s = irq_s2_r[2];
  // Nothing is accepted while asleep; the pipeline holds its word
  assign fire = issue_valid && issue_ready;
  assign reserved_op = !RELEASE2 &&
    (op == itwle_pkg::ITWLE_OP_SHADOW_WR ||
     op == itwle_pkg::ITWLE_OP_WSBH);
  // Event that restarts the pipeline
  assign wake_ev = nmi_s || (irq_p && (irq_e || WAKE_ON_MASKED));

  // Trap conditions
  always_comb
  begin
    trap_hit = 1'b0;
    case (op)
      itwle_pkg::ITWLE_OP_TRAP_LTU:
        trap_hit = ({1'b0, opnd_a} < {1'b0, opnd_b});
      itwle_pkg::ITWLE_OP_TRAP_NE:
        trap_hit = (opnd_a != opnd_b);
      itwle_pkg::ITWLE_OP_TRAP_NEI:
        trap_hit = (opnd_a != imm_sx);
      default:
        trap_hit = 1'b0;
    endcase
  end

  // Two-flop synchronisers for the asynchronous wake pins
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_s1_r <= 3'h0;
      irq_s2_r <= 3'h0;
    end
    else
    begin
      irq_s1_r <= {nmi_in, irq_enabled, irq_pending};
      irq_s2_r <= irq_s1_r;
    end
  end

  // Standby state machine
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ITWLE_RUN; // Reset also ends any standby
      resume_pc_r <= 32'h0000_0000;
      standby_r <= 1'b0;
      issue_ready <= 1'b1; // Ready straight out of reset
    end
    else
    begin
      case (state_r)
        ITWLE_RUN:
        begin
          // Enter only when access allowed
          if (fire && op == itwle_pkg::ITWLE_OP_WAIT && syscop_usable)
          begin
            state_r <= ITWLE_SLEEP;
            resume_pc_r <= issue_pc + `ITWLE_PC_STEP;
            standby_r <= 1'b1;
            // Registered so the stall shows from the next cycle on
            issue_ready <= 1'b0;
          end
        end
        ITWLE_SLEEP:
        begin
          // Delay-slot placement is software's problem
          if (wake_ev)
          begin
            state_r <= ITWLE_RUN;
            standby_r <= 1'b0;
            issue_ready <= 1'b1;
          end
        end
        default:
        begin
          state_r <= ITWLE_RUN;
          standby_r <= 1'b0;
          issue_ready <= 1'b1;
        end
      endcase
    end
  end

  // Exception reporting
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      exc_valid_r <= 1'b0;
      exc_code_r <= itwle_pkg::ITWLE_EXC_NONE;
      exc_pc_r <= 32'h0000_0000;
      wake_masked_r <= 1'b0;
    end
    else
    begin
      exc_valid_r <= 1'b0;
      if (state_r == ITWLE_SLEEP)
      begin
        if (wake_ev)
        begin
          // Interrupt and NMI vector through exception unit; here we
          // only hand back the successor address
          exc_pc_r <= resume_pc_r;
          wake_masked_r <= !nmi_s && !irq_e;
        end
      end
      else if (fire)
      begin
        wake_masked_r <= 1'b0;
        if (reserved_op)
        begin
          exc_valid_r <= 1'b1;
          exc_code_r <= itwle_pkg::ITWLE_EXC_RI;
          exc_pc_r <= issue_pc;
        end
        else if (op == itwle_pkg::ITWLE_OP_WAIT && !syscop_usable)
        begin
          exc_valid_r <= 1'b1;
          exc_code_r <= itwle_pkg::ITWLE_EXC_CPU;
          exc_pc_r <= issue_pc;
        end
        else if (trap_hit)
        begin
          exc_valid_r <= 1'b1;
          exc_code_r <= itwle_pkg::ITWLE_EXC_TRAP;
          exc_pc_r <= issue_pc;
        end
      end
    end
  end

  // Register write-back; suppressed on any exception
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      claimed_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_idx_r <= 5'h00;
      wr_data_r <= 32'h0000_0000;
      sh_wr_en_r <= 1'b0;
      sh_set_r <= '0;
    end
    else
    begin
      claimed_r <= fire && (op != itwle_pkg::ITWLE_OP_NONE);
      wr_en_r <= 1'b0;
      sh_wr_en_r <= 1'b0;
      if (fire && !reserved_op)
      begin
        case (op)
          itwle_pkg::ITWLE_OP_XOR:
          begin
            wr_en_r <= 1'b1;
            wr_idx_r <= rd_f;
            wr_data_r <= opnd_a ^ opnd_b;
          end
          itwle_pkg::ITWLE_OP_XOR_IMM:
          begin
            wr_en_r <= 1'b1;
            wr_idx_r <= srcb_f;
            wr_data_r <= opnd_a ^ imm_zx;
          end
          itwle_pkg::ITWLE_OP_WSBH:
          begin
            wr_en_r <= 1'b1;
            wr_idx_r <= rd_f;
            wr_data_r <= swap_halves(opnd_b);
          end
          itwle_pkg::ITWLE_OP_SHADOW_WR:
          begin
            sh_wr_en_r <= 1'b1;
            sh_set_r <= previous_shadow_set;
            wr_idx_r <= rd_f;
            wr_data_r <= opnd_b;
          end
          default:
            wr_en_r <= 1'b0;
        endcase
      end
    end
  end

  // Checks
  sequence sleep_entry_s;
    fire && op == itwle_pkg::ITWLE_OP_WAIT && syscop_usable;
  endsequence

  trap_precise_a: assert property (@(posedge clock) disable iff (!arst_n)
    fire && trap_hit && !reserved_op |=> exc_valid_r && !wr_en_r &&
    exc_pc_r == $past(issue_pc))
    else $error("trap not precise");
  ltu_compare_a: assert property (@(posedge clock) disable iff (!arst_n)
    fire && op == itwle_pkg::ITWLE_OP_TRAP_LTU && opnd_a < opnd_b
    |=> exc_code_r == itwle_pkg::ITWLE_EXC_TRAP)
    else $error("unsigned trap missed");
  ne_compare_a: assert property (@(posedge clock) disable iff (!arst_n)
    fire && op == itwle_pkg::ITWLE_OP_TRAP_NE && opnd_a == opnd_b
    |=> !exc_valid_r)
    else $error("equal operands trapped");
  nei_compare_a: assert property (@(posedge clock) disable iff (!arst_n)
    fire && op == itwle_pkg::ITWLE_OP_TRAP_NEI && opnd_a != imm_sx
    |=> exc_valid_r)
    else $error("immediate trap missed");
  sleep_stall_a: assert property (@(posedge clock) disable iff (!arst_n)
    sleep_entry_s ##1 !wake_ev |-> !issue_ready ##0 standby_r)
    else $error("standby did not stall");
  nmi_wake_a: assert property (@(posedge clock) disable iff (!arst_n)
    standby_r && nmi_s |=> !standby_r && issue_ready)
    else $error("nmi did not restart");
  // Any wake, however long the sleep, hands back the successor
  wake_epc_a: assert property (@(posedge clock) disable iff (!arst_n)
    standby_r && wake_ev
    |=> exc_pc_r == $past(resume_pc_r) && !standby_r)
    else $error("wake return address wrong");
  cpu_unusable_a: assert property (@(posedge clock) disable iff (!arst_n)
    fire && op == itwle_pkg::ITWLE_OP_WAIT && !syscop_usable
    |=> exc_code_r == itwle_pkg::ITWLE_EXC_CPU && !standby_r)
    else $error("standby entered without access");
  wsbh_order_a: assert property (@(posedge clock) disable iff (!arst_n)
    fire && op == itwle_pkg::ITWLE_OP_WSBH && RELEASE2
    |=> wr_en_r && wr_data_r == swap_halves($past(opnd_b)))
    else $error("byte swap wrong");
  ximm_zext_a: assert property (@(posedge clock) disable iff (!arst_n)
    fire && op == itwle_pkg::ITWLE_OP_XOR_IMM
    |=> wr_data_r[31:16] == $past(opnd_a[31:16]))
    else $error("exclusive_or_immediate upper half altered");
endmodule

// ### include/itwle_cfg.svh
`ifndef ITWLE_CFG_SVH
`define ITWLE_CFG_SVH
// Instruction field positions
`define ITWLE_OP_HI 31
`define ITWLE_OP_LO 26
`define ITWLE_SRCA_HI 25
`define ITWLE_SRCA_LO 21
`define ITWLE_SRCB_HI 20
`define ITWLE_SRCB_LO 16
`define ITWLE_RD_HI 15
`define ITWLE_RD_LO 11
`define ITWLE_SA_HI 10
`define ITWLE_SA_LO 6
`define ITWLE_FN_HI 5
`define ITWLE_FN_LO 0
`define ITWLE_IMM_HI 15
`define ITWLE_IMM_LO 0
`define ITWLE_SYSOP_BIT 25
`define ITWLE_WCODE_HI 24
`define ITWLE_WCODE_LO 6
// Primary opcodes
`define ITWLE_OP_REGOP 6'h00
`define ITWLE_OP_REGISTER_IMMEDIATE_CLASS 6'h01
`define ITWLE_OP_SYSCOP 6'h10
`define ITWLE_OPC_XOR_IMM 6'h0e
`define ITWLE_OP_THIRD 6'h1f
// Function and sub-field codes
`define ITWLE_FN_TRAP_LTU 6'h33
`define ITWLE_FN_TRAP_NE 6'h36
`define ITWLE_FN_XOR 6'h26
`define ITWLE_FN_WAIT 6'h20
`define ITWLE_FN_SHUFFLE 6'h20
`define ITWLE_SRCB_TRAP_NEI 5'h0e
`define ITWLE_SRCA_SHADOW_WR 5'h0e
// Address step to the next instruction, WSBH shift code and zero field values
`define ITWLE_PC_STEP 32'h0000_0004
`define ITWLE_SA_WSBH 5'h02
`define ITWLE_ZERO5 5'h00
`define ITWLE_ZERO11 11'h000
`endif

// ### include/itwle_pkg.sv
package itwle_pkg;
  // Exception codes reported to the exception unit
  typedef enum logic [2:0] {
    ITWLE_EXC_NONE,
    ITWLE_EXC_TRAP,
    ITWLE_EXC_CPU,
    ITWLE_EXC_RI
  } itwle_exc_type;
  // Instructions this block recognises
  typedef enum logic [3:0] {
    ITWLE_OP_NONE,
    ITWLE_OP_TRAP_LTU,
    ITWLE_OP_TRAP_NE,
    ITWLE_OP_TRAP_NEI,
    ITWLE_OP_WAIT,
    ITWLE_OP_SHADOW_WR,
    ITWLE_OP_WSBH,
    ITWLE_OP_XOR,
    ITWLE_OP_XOR_IMM
  } itwle_op_type;
endpackage

// ### rtl/itwle_decode.sv
`timescale 1ns/1ps
`include "itwle_cfg.svh"
// Pure decoder: classifies one instruction word
module itwle_decode
(
  input wire logic [31:0] instr, // Instruction word
  output itwle_pkg::itwle_op_type op // Recognised operation
);
  logic [5:0] opc;
  logic [4:0] srca_f;
  logic [4:0] srcb_f;
  logic [4:0] sa_f;
  logic [5:0] fn_f;
  assign opc = instr[`ITWLE_OP_HI:`ITWLE_OP_LO];
  assign srca_f = instr[`ITWLE_SRCA_HI:`ITWLE_SRCA_LO];
  assign srcb_f = instr[`ITWLE_SRCB_HI:`ITWLE_SRCB_LO];
  assign sa_f = instr[`ITWLE_SA_HI:`ITWLE_SA_LO];
  assign fn_f = instr[`ITWLE_FN_HI:`ITWLE_FN_LO];
  // Code field of traps is never looked at
  always_comb
  begin
    op = itwle_pkg::ITWLE_OP_NONE;
    case (opc)
      `ITWLE_OP_REGOP:
      begin
        if (fn_f == `ITWLE_FN_TRAP_LTU)
          op = itwle_pkg::ITWLE_OP_TRAP_LTU;
        else if (fn_f == `ITWLE_FN_TRAP_NE)
          op = itwle_pkg::ITWLE_OP_TRAP_NE;
        else if (fn_f == `ITWLE_FN_XOR && sa_f == `ITWLE_ZERO5)
          op = itwle_pkg::ITWLE_OP_XOR;
      end
      `ITWLE_OP_REGISTER_IMMEDIATE_CLASS:
      begin
        if (srcb_f == `ITWLE_SRCB_TRAP_NEI)
          op = itwle_pkg::ITWLE_OP_TRAP_NEI;
      end
      `ITWLE_OP_SYSCOP:
      begin
        // Bits 24:6 are hint only; any value, zero included, is accepted
        if (instr[`ITWLE_SYSOP_BIT] && fn_f == `ITWLE_FN_WAIT)
          op = itwle_pkg::ITWLE_OP_WAIT;
        else if (srca_f == `ITWLE_SRCA_SHADOW_WR)
          op = itwle_pkg::ITWLE_OP_SHADOW_WR;
      end
      `ITWLE_OP_THIRD:
      begin
        if (fn_f == `ITWLE_FN_SHUFFLE && sa_f == `ITWLE_SA_WSBH &&
            srca_f == `ITWLE_ZERO5)
          op = itwle_pkg::ITWLE_OP_WSBH;
      end
      `ITWLE_OPC_XOR_IMM:
        op = itwle_pkg::ITWLE_OP_XOR_IMM;
      default:
        op = itwle_pkg::ITWLE_OP_NONE;
    endcase
  end
endmodule

// ### tb/itwle_pipe_model.sv
`timescale 1ns/1ps
// Fetch stage and register file that sit beside the block
module itwle_pipe_model
(
  input wire logic clock, // Core clock
  input wire logic issue_ready, // Block accepts a word
  input wire logic wr_en_r, // Current-set write
  input wire logic [4:0] wr_idx_r, // Write index
  input wire logic [31:0] wr_data_r, // Write data
  input wire logic sh_wr_en_r, // Shadow-set write
  input wire logic [3:0] sh_set_r, // Shadow set number
  output logic issue_valid, // Word presented
  output logic [31:0] issue_instr, // Instruction word
  output logic [31:0] issue_pc, // Word address
  output logic [31:0] opnd_a, // source_reg_a value
  output logic [31:0] opnd_b // source_reg_b value
);
  logic [31:0] gpr [32]; // Current register set
  logic [31:0] sgpr [16][32]; // Shadow register sets

  // Idle bus at time zero
  initial
  begin
    issue_valid = 1'b0;
    issue_instr = 32'h0000_0000;
    issue_pc = 32'h0000_0000;
    opnd_a = 32'h0000_0000;
    opnd_b = 32'h0000_0000;
  end

  // Words go out one by one with no branch around them
  // Held until taken; a stalled block keeps the word waiting
  task automatic issue(input logic [31:0] w, pc, a, b);
    issue_valid = 1'b1;
    issue_instr = w;
    issue_pc = pc;
    opnd_a = a;
    opnd_b = b;
    while (issue_ready !== 1'b1)
      @(posedge clock) #1;
    @(posedge clock);
    #1;
  endtask

  // Released bus shows inverted data so stale values never match
  task automatic idle;
    issue_valid = 1'b0;
    issue_instr = ~issue_instr;
    opnd_a = ~opnd_a;
    opnd_b = ~opnd_b;
  endtask

  // Register file takes the block's writes
  always @(posedge clock)
  begin
    if (wr_en_r)
      gpr[wr_idx_r] <= wr_data_r;
    if (sh_wr_en_r)
      sgpr[sh_set_r][wr_idx_r] <= wr_data_r;
  end
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
// Self-checking bench for the trap, standby and logic group
module tb;
  logic clock, arst_n, syscop_usable, irq_pending, irq_enabled, nmi_in;
  logic issue_valid, issue_ready, claimed_r, wr_en_r, sh_wr_en_r;
  logic exc_valid_r, standby_r, wake_masked_r;
  logic [31:0] issue_instr, issue_pc, opnd_a, opnd_b, wr_data_r, exc_pc_r;
  logic [4:0] wr_idx_r; // Destination index
  logic [3:0] previous_shadow_set, sh_set_r; // Shadow set numbers
  itwle_pkg::itwle_exc_type exc_code_r; // Exception kind
  int n_errors = 0; // Mismatches
  int num_checks = 0; // Comparisons
  int cycles = 0; // Hang guard
  int i; // Wake latency count
  localparam logic [31:0] WAITW = {6'h10, 1'b1, 19'h0, 6'h20}; // Standby

  itwle_exec #(.RELEASE2(1'b1), .WAKE_ON_MASKED(1'b0), .SETS_W(4)) DUT (
    .clock(clock), .arst_n(arst_n), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .issue_pc(issue_pc), .opnd_a(opnd_a),
    .opnd_b(opnd_b), .syscop_usable(syscop_usable),
    .previous_shadow_set(previous_shadow_set), .irq_pending(irq_pending),
    .irq_enabled(irq_enabled), .nmi_in(nmi_in), .issue_ready(issue_ready),
    .claimed_r(claimed_r), .wr_en_r(wr_en_r), .wr_idx_r(wr_idx_r),
    .wr_data_r(wr_data_r), .sh_wr_en_r(sh_wr_en_r), .sh_set_r(sh_set_r),
    .exc_valid_r(exc_valid_r), .exc_code_r(exc_code_r),
    .exc_pc_r(exc_pc_r), .standby_r(standby_r),
    .wake_masked_r(wake_masked_r));

  itwle_pipe_model pipe (
    .clock(clock), .issue_ready(issue_ready), .wr_en_r(wr_en_r),
    .wr_idx_r(wr_idx_r), .wr_data_r(wr_data_r), .sh_wr_en_r(sh_wr_en_r),
    .sh_set_r(sh_set_r), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .issue_pc(issue_pc), .opnd_a(opnd_a),
    .opnd_b(opnd_b));

  // 125 MHz clock
  always #4 clock = ~clock;

  // Cut a hang short; generous against about 50 cycles of tests
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  // Compare one value, four-state
  task automatic check(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step;
    @(posedge clock);
    #1;
  endtask

  // Claim, write and exception pulses together
  task automatic res(input logic cl, we, ex);
    check(claimed_r, cl);
    check(wr_en_r, we);
    check(exc_valid_r, ex);
  endtask

  // Idle edge, then one word; its answer stands on return
  task automatic one(input logic [31:0] w, pc, a, b);
    step();
    pipe.issue(w, pc, a, b);
    pipe.idle();
  endtask

  // Unsigned compare; top bit set would flip a signed result
  task automatic t_trap_less_unsigned;
    one({6'h00, 5'h01, 5'h02, 10'h3a5, 6'h33}, 32'h100, 32'h1, 32'h8000_0000);
    res(1'b1, 1'b0, 1'b1);
    check(exc_code_r, itwle_pkg::ITWLE_EXC_TRAP);
    check(exc_pc_r, 32'h100);
    one({6'h00, 5'h01, 5'h02, 10'h3ff, 6'h33}, 32'h104, 32'hffff_ffff, 32'h1);
    res(1'b1, 1'b0, 1'b0);
  endtask

  // Equal trap then XOR back to back, then a real trap
  task automatic t_tne_xor;
    step();
    pipe.issue({6'h00, 5'h03, 5'h04, 10'h155, 6'h36}, 32'h200, 32'h5, 32'h5);
    res(1'b1, 1'b0, 1'b0);
    pipe.issue({6'h00, 5'h03, 5'h04, 5'h07, 5'h00, 6'h26}, 32'h204,
      32'hf0f0_1234, 32'h0ff0_4321);
    pipe.idle();
    res(1'b1, 1'b1, 1'b0);
    check(wr_idx_r, 5'h07);
    check(wr_data_r, 32'hff00_5115);
    one({6'h00, 5'h03, 5'h04, 10'h000, 6'h36}, 32'h208, 32'h5, 32'h6);
    res(1'b1, 1'b0, 1'b1);
    check(exc_pc_r, 32'h208);
    // Nonzero shift field is not an XOR
    one({6'h00, 5'h03, 5'h04, 5'h07, 5'h01, 6'h26}, 32'h20c, 32'h1, 32'h2);
    res(1'b0, 1'b0, 1'b0);
  endtask

  // Immediate trap and immediate XOR, with the sign bit of imm set
  task automatic t_imm;
    one({6'h01, 5'h03, 5'h0e, 16'hffff}, 32'h300, 32'hffff_ffff, 32'h0);
    res(1'b1, 1'b0, 1'b0);
    one({6'h01, 5'h03, 5'h0e, 16'hffff}, 32'h304, 32'h0000_ffff, 32'h0);
    res(1'b1, 1'b0, 1'b1);
    check(exc_pc_r, 32'h304);
    one({6'h0e, 5'h01, 5'h09, 16'h8001}, 32'h308, 32'hffff_0000, 32'h0);
    res(1'b1, 1'b1, 1'b0);
    check(wr_idx_r, 5'h09);
    check(wr_data_r, 32'hffff_8001);
  endtask

  // Byte swap and shadow-set write
  task automatic t_swap_shadow;
    one({6'h1f, 5'h00, 5'h04, 5'h0b, 5'h02, 6'h20}, 32'h400, 32'h0,
      32'h1122_3344);
    res(1'b1, 1'b1, 1'b0);
    check(wr_idx_r, 5'h0b);
    check(wr_data_r, 32'h2211_4433);
    previous_shadow_set = 4'h5;
    one({6'h10, 5'h0e, 5'h04, 5'h0c, 11'h000}, 32'h404, 32'h0, 32'hcafe_0001);
    res(1'b1, 1'b0, 1'b0);
    check(sh_wr_en_r, 1'b1);
    check(sh_set_r, 4'h5);
    step();
    check(pipe.sgpr[5][12], 32'hcafe_0001);
  endtask

  // Pin set one edge earlier; second synchroniser edge, then the state register edge, end standby
  task automatic wake(input logic [31:0] pc);
    for (i = 0; i < 10 && standby_r !== 1'b0; i++)
      step();
    check(i, 2);
    check(issue_ready, 1'b1);
    check(exc_pc_r, pc + 32'h4);
  endtask

  // Standby: refused, masked request, enabled wake, NMI, reset
  task automatic t_wait;
    syscop_usable = 1'b0;
    one(WAITW, 32'h500, 32'h0, 32'h0);
    res(1'b1, 1'b0, 1'b1);
    check(exc_code_r, itwle_pkg::ITWLE_EXC_CPU);
    check(standby_r, 1'b0);
    syscop_usable = 1'b1;
    one(WAITW | 32'h0155_5540, 32'h600, 32'h0, 32'h0);
    check(standby_r, 1'b1);
    check(issue_ready, 1'b0);
    irq_pending = 1'b1;
    repeat (6) step();
    check(standby_r, 1'b1);
    check(wake_masked_r, 1'b0);
    irq_enabled = 1'b1;
    step();
    wake(32'h600);
    irq_pending = 1'b0;
    // Let the synchronised request drain before sleeping again
    repeat (2) step();
    one(WAITW, 32'h700, 32'h0, 32'h0);
    check(standby_r, 1'b1);
    nmi_in = 1'b1;
    step();
    wake(32'h700);
    nmi_in = 1'b0;
    repeat (2) step();
    one(WAITW, 32'h800, 32'h0, 32'h0);
    check(standby_r, 1'b1);
    arst_n = 1'b0;
    step();
    check(standby_r, 1'b0);
    check(issue_ready, 1'b1);
    arst_n = 1'b1;
    step();
  endtask

  // Counts, verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    clock = 1'b0;
    arst_n = 1'b0;
    syscop_usable = 1'b1;
    previous_shadow_set = 4'h0;
    irq_pending = 1'b0;
    irq_enabled = 1'b0;
    nmi_in = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    arst_n = 1'b1;
    t_trap_less_unsigned();
    t_tne_xor();
    t_imm();
    t_swap_shadow();
    t_wait();
    tally_and_finish();
  end
endmodule
